// >>> hdl/rtc_defines.svh
// register indexes, field positions, reset values and sync timing of the counter control block
//
// Contract
// - clear_on_match set clears the counter on a match0; clear lets it run on
// - two-bit mode field selects 32-bit, 16-bit or calendar; code 3 reserved; unsynchronized; calendar and code 3 count as 32-bit here
// - enable write reads back at once, sets enable busy until counter side follows
// - soft reset resets all registers except debug_control and disables the block
// - a write that sets soft reset discards every other bit of that write
// - soft reset bit reads 1 until the synchronized reset has finished
// - overflow event emitted on every overflow only while its enable is 1
// - match0 event emitted on every compare match only while its enable is 1
// - event control bits 7..0 enable periodic event n each
// - enable-clear write 1 clears an enable, 0 no effect, reads shared state
// - enable-set write 1 sets an enable, 0 no effect, shares enable state
// - overflow flag set the tick after overflow, interrupt if its enable set
// - match0 flag set the tick after a match, interrupt if its enable set
// - periodic flag n set when prescaler bit n+2 rises, interrupt if enabled
// - flags clear only on software writing 1; writing 0 leaves them; a finished soft reset also clears them here
// - run_in_debug 0 halts counting under debug halt; soft reset keeps it
// - busy bits 16 and 17 track scratch word 0 and 1 write synchronization
// - busy bit 15 tracks synchronization of the count read sync enable bit
// - busy bit 5 tracks synchronization of a match0 value write
// - busy bit 3 tracks read or write synchronization of the counter value
// - busy bit 2 tracks synchronization of the rate trim register
// - busy bits 1 and 0 track enable and soft reset synchronization
// - no periodic events while the prescaler code is zero
// - counter reads without count read sync enable return no valid value
// - prescaler codes 0,1 divide by 1, up to 0xB by 1024, above reserved
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_IDX_CONTROL_A   8'h00
`define RTC_IDX_EVENT_CTRL  8'h04
`define RTC_IDX_IEN_CLEAR   8'h08
`define RTC_IDX_IEN_SET     8'h0A
`define RTC_IDX_FLAGS       8'h0C
`define RTC_IDX_DEBUG       8'h0E
`define RTC_IDX_PENDING     8'h10
`define RTC_IDX_RATE_TRIM   8'h14
`define RTC_IDX_COUNT       8'h18
`define RTC_IDX_MATCH0      8'h20
`define RTC_IDX_SCRATCH0    8'h40
`define RTC_IDX_SCRATCH1    8'h44
`define RTC_CA_SOFT_RESET   0
`define RTC_CA_ENABLE       1
`define RTC_CA_MODE_LO      2
`define RTC_CA_MODE_HI      3
`define RTC_CA_CLEAR_MATCH  7
`define RTC_CA_PRESC_LO     8
`define RTC_CA_PRESC_HI     11
`define RTC_CA_READ_SYNC    15
`define RTC_BIT_OVERFLOW    15
`define RTC_BIT_MATCH0      8
`define RTC_BIT_PERIODIC_HI 7
`define RTC_LIVE_MASK       16'h81FF
`define RTC_DEBUG_RUN       0
`define RTC_RESET_WORD      32'h00000000
`define RTC_TOP_HALF        32'h0000FFFF
`define RTC_TOP_WIDE        32'hFFFFFFFF
`define RTC_PRESC_MAX       4'hB
`define RTC_PERIODIC_TAP    2
`define RTC_PRESC_BITS      10
`define RTC_SYNC_CYCLES     4
`define RTC_CH_SOFT_RESET   0
`define RTC_CH_ENABLE       1
`define RTC_CH_RATE_TRIM    2
`define RTC_CH_COUNT        3
`define RTC_CH_MATCH0       4
`define RTC_CH_READ_SYNC    5
`define RTC_CH_SCRATCH0     6
`define RTC_CH_SCRATCH1     7
`define RTC_CHANNELS        8
`define RTC_SB_MATCH0       5
`define RTC_SB_READ_SYNC    15
`define RTC_SB_SCRATCH0     16
`define RTC_SB_SCRATCH1     17
`endif

// >>> hdl/rtc_pkg.sv
// shared types of the counter control block
package rtc_pkg;
  typedef enum logic [1:0] {
    WIDE_COUNTER_MODE,
    HALF_COUNTER_MODE,
    CALENDAR_MODE,
    RESERVED_MODE
  } rtc_mode_e;

  typedef struct packed {
    logic       overflow;
    logic       match0;
    logic [7:0] periodic;
  } rtc_evt_s;
endpackage : rtc_pkg

// >>> hdl/rtc_prescaler.sv
// prescaler: counter tick and periodic interval edges
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_prescaler #(
  parameter int WIDTH   = `RTC_PRESC_BITS,
  parameter int TAP     = `RTC_PERIODIC_TAP,
  parameter int PERIODS = `RTC_BIT_PERIODIC_HI + 1
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               clear,
  input  wire logic               run,
  input  wire logic [3:0]         code,
  output logic                    tick,
  output logic [PERIODS-1:0]      periodic
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } rtc_presc_s;

  rtc_presc_s       s;
  rtc_presc_s       n;
  logic [WIDTH-1:0] nxt;
  logic [WIDTH-1:0] mask;

  // low bits that must all be one for a counter tick
  function automatic logic [WIDTH-1:0] divMask(input logic [3:0] c);
    logic [3:0]       k;
    logic [WIDTH-1:0] one;
    one = {{(WIDTH-1){1'b0}}, 1'b1};
    k = (c > `RTC_PRESC_MAX) ? `RTC_PRESC_MAX : c;
    if (k <= 4'h1) begin
      return '0;
    end
    return (one << (k - 4'h1)) - one;
  endfunction : divMask

  always_comb begin
    nxt = s.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    mask = divMask(code);
    n = s;
    if (clear) begin
      n.cnt = '0;
    end else if (run) begin
      n.cnt = nxt;
    end
    tick = run & ((s.cnt & mask) == mask);
    if (run && code != 4'h0) begin
      periodic = nxt[TAP+PERIODS-1:TAP] & ~s.cnt[TAP+PERIODS-1:TAP];
    end else begin
      periodic = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : rtc_prescaler

// >>> hdl/rtc_sync_busy.sv
// per-channel synchronization busy timers
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_sync_busy #(
  parameter int CHANNELS = `RTC_CHANNELS,
  parameter int LENGTH   = `RTC_SYNC_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                clear,
  input  wire logic [CHANNELS-1:0] start,
  output logic      [CHANNELS-1:0] busy,
  output logic      [CHANNELS-1:0] done
);
  localparam int CW = $clog2(LENGTH + 1);

  typedef struct packed {
    logic [CHANNELS-1:0][CW-1:0] cnt;
  } rtc_sync_s;

  rtc_sync_s s;
  rtc_sync_s n;

  always_comb begin
    n = s;
    for (int i = 0; i < CHANNELS; i++) begin
      busy[i] = s.cnt[i] != '0;
      done[i] = s.cnt[i] == CW'(1);
      if (clear) begin
        n.cnt[i] = '0;
      end else if (start[i]) begin
        n.cnt[i] = CW'(LENGTH);
      end else if (busy[i]) begin
        n.cnt[i] = s.cnt[i] - CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : rtc_sync_busy

// >>> hdl/rtc_wide_counter_mode_ctrl.sv
// control, event, interrupt, debug and busy registers of the 32-bit counter
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_wide_counter_mode_ctrl #(
  parameter int SYNC_CYCLES = `RTC_SYNC_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       dbgHalt,
  output logic            irq,
  output rtc_pkg::rtc_evt_s evtOut
);
  typedef struct packed {
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic                softReset;
    logic                enable;
    logic                enableLive;
    logic                clearOnMatch;
    logic                countReadSyncEn;
    rtc_pkg::rtc_mode_e  mode;
    logic [3:0]          presc;
    logic [15:0]         eventOutputControl;
    logic [15:0]         irqEnable;
    logic [15:0]         irqFlags;
    logic                runInDebug;
    logic                haltMeta;
    logic                haltSync;
    logic [7:0]          rateTrim;
    logic [31:0]         count;
    logic [31:0]         countWr;
    logic                countWrPend;
    logic [31:0]         match0Value;
    logic [31:0]         match0Wr;
    logic [31:0]         scratch0;
    logic [31:0]         scratch1;
    logic                irq;
    rtc_pkg::rtc_evt_s   evt;
  } rtc_ctrl_s;

  rtc_ctrl_s                 s;
  rtc_ctrl_s                 n;
  logic                      accept;
  logic                      wrAcc;
  logic                      firstRead;
  logic [7:0]                idx;
  logic                      hit;
  logic [31:0]               rdWord;
  logic                      idle;
  logic                      halted;
  logic                      run;
  logic                      tick;
  logic [7:0]                periodic;
  logic                      overflow;
  logic                      match;
  logic [15:0]                setMask;
  logic [15:0]                clrMask;
  logic [`RTC_CHANNELS-1:0]  start;
  logic [`RTC_CHANNELS-1:0]  busy;
  logic [`RTC_CHANNELS-1:0]  done;
  logic [31:0]               pendWord;

  rtc_prescaler u_presc (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .clear    (done[`RTC_CH_SOFT_RESET]),
    .run      (run),
    .code     (s.presc),
    .tick     (tick),
    .periodic (periodic)
  );

  rtc_sync_busy #(
    .CHANNELS (`RTC_CHANNELS),
    .LENGTH   (SYNC_CYCLES)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (done[`RTC_CH_SOFT_RESET]),
    .start   (start),
    .busy    (busy),
    .done    (done)
  );

  // busy channels placed at their status word positions
  always_comb begin
    pendWord = `RTC_RESET_WORD;
    pendWord[`RTC_CA_SOFT_RESET] = busy[`RTC_CH_SOFT_RESET];
    pendWord[`RTC_CA_ENABLE] = busy[`RTC_CH_ENABLE];
    pendWord[`RTC_CH_RATE_TRIM] = busy[`RTC_CH_RATE_TRIM];
    pendWord[`RTC_CH_COUNT] = busy[`RTC_CH_COUNT];
    pendWord[`RTC_SB_MATCH0] = busy[`RTC_CH_MATCH0];
    pendWord[`RTC_SB_READ_SYNC] = busy[`RTC_CH_READ_SYNC];
    pendWord[`RTC_SB_SCRATCH0] = busy[`RTC_CH_SCRATCH0];
    pendWord[`RTC_SB_SCRATCH1] = busy[`RTC_CH_SCRATCH1];
  end

  // read decode
  always_comb begin
    idx = paddr[9:2];
    hit = paddr[11:10] == 2'b00;
    rdWord = `RTC_RESET_WORD;
    unique case (idx)
      `RTC_IDX_CONTROL_A: begin
        rdWord[`RTC_CA_SOFT_RESET] = s.softReset;
        rdWord[`RTC_CA_ENABLE] = s.enable;
        rdWord[`RTC_CA_MODE_HI:`RTC_CA_MODE_LO] = s.mode;
        rdWord[`RTC_CA_CLEAR_MATCH] = s.clearOnMatch;
        rdWord[`RTC_CA_PRESC_HI:`RTC_CA_PRESC_LO] = s.presc;
        rdWord[`RTC_CA_READ_SYNC] = s.countReadSyncEn;
      end
      `RTC_IDX_EVENT_CTRL: rdWord[15:0] = s.eventOutputControl;
      `RTC_IDX_IEN_CLEAR: rdWord[15:0] = s.irqEnable;
      `RTC_IDX_IEN_SET: rdWord[15:0] = s.irqEnable;
      `RTC_IDX_FLAGS: rdWord[15:0] = s.irqFlags;
      `RTC_IDX_DEBUG: rdWord[`RTC_DEBUG_RUN] = s.runInDebug;
      `RTC_IDX_PENDING: rdWord = pendWord;
      `RTC_IDX_RATE_TRIM: rdWord[7:0] = s.rateTrim;
      `RTC_IDX_COUNT: begin
        if (s.countReadSyncEn) begin
          rdWord = s.count;
        end else begin
          rdWord = `RTC_RESET_WORD;
        end
      end
      `RTC_IDX_MATCH0: rdWord = s.match0Wr;
      `RTC_IDX_SCRATCH0: rdWord = s.scratch0;
      `RTC_IDX_SCRATCH1: rdWord = s.scratch1;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    n = s;
    start = '0;
    clrMask = '0;
    setMask = '0;
    overflow = 1'b0;
    match = 1'b0;
    accept = psel & penable & s.pready;
    wrAcc = accept & pwrite & hit;
    firstRead = psel & penable & ~s.pready & ~pwrite & hit;
    idle = ~s.enable & ~s.enableLive;

    // bus answer one cycle after the access phase opens
    n.pready = psel & penable & ~s.pready;
    n.pslverr = n.pready & ~hit;
    n.prdata = (n.pready && !pwrite && hit) ? rdWord : `RTC_RESET_WORD;
    if (firstRead && idx == `RTC_IDX_COUNT && s.countReadSyncEn) begin
      start[`RTC_CH_COUNT] = 1'b1;
    end

    // debug halt input synchronizer
    n.haltMeta = dbgHalt;
    n.haltSync = s.haltMeta;

    // counter advance
    if (tick) begin
      match = s.count == s.match0Value;
      if (s.mode == rtc_pkg::HALF_COUNTER_MODE) begin
        overflow = s.count[15:0] == `RTC_TOP_HALF;
      end else begin
        overflow = s.count == `RTC_TOP_WIDE;
      end
      if (match && s.clearOnMatch) begin
        n.count = `RTC_RESET_WORD;
      end else if (overflow) begin
        n.count = `RTC_RESET_WORD;
      end else begin
        n.count = s.count + 32'h00000001;
      end
    end

    // events
    n.evt.overflow = overflow & s.eventOutputControl[`RTC_BIT_OVERFLOW];
    n.evt.match0 = match & s.eventOutputControl[`RTC_BIT_MATCH0];
    n.evt.periodic = periodic & s.eventOutputControl[`RTC_BIT_PERIODIC_HI:0];

    // flag sources
    setMask[`RTC_BIT_OVERFLOW] = overflow;
    setMask[`RTC_BIT_MATCH0] = match;
    setMask[`RTC_BIT_PERIODIC_HI:0] = periodic;

    // register writes
    if (wrAcc) begin
      unique case (idx)
        `RTC_IDX_CONTROL_A: begin
          if (pwdata[`RTC_CA_SOFT_RESET]) begin
            n.softReset = 1'b1;
            start[`RTC_CH_SOFT_RESET] = 1'b1;
          end else begin
            n.enable = pwdata[`RTC_CA_ENABLE];
            start[`RTC_CH_ENABLE] = 1'b1;
            n.countReadSyncEn = pwdata[`RTC_CA_READ_SYNC];
            start[`RTC_CH_READ_SYNC] = 1'b1;
            if (idle) begin
              n.mode = rtc_pkg::rtc_mode_e'(pwdata[`RTC_CA_MODE_HI:`RTC_CA_MODE_LO]);
              n.clearOnMatch = pwdata[`RTC_CA_CLEAR_MATCH];
              n.presc = pwdata[`RTC_CA_PRESC_HI:`RTC_CA_PRESC_LO];
            end
          end
        end
        `RTC_IDX_EVENT_CTRL: begin
          if (idle) begin
            n.eventOutputControl = pwdata[15:0] & `RTC_LIVE_MASK;
          end
        end
        `RTC_IDX_IEN_CLEAR: begin
          n.irqEnable = s.irqEnable & ~(pwdata[15:0] & `RTC_LIVE_MASK);
        end
        `RTC_IDX_IEN_SET: begin
          n.irqEnable = s.irqEnable | (pwdata[15:0] & `RTC_LIVE_MASK);
        end
        `RTC_IDX_FLAGS: clrMask = pwdata[15:0] & `RTC_LIVE_MASK;
        `RTC_IDX_DEBUG: n.runInDebug = pwdata[`RTC_DEBUG_RUN];
        `RTC_IDX_RATE_TRIM: begin
          n.rateTrim = pwdata[7:0];
          start[`RTC_CH_RATE_TRIM] = 1'b1;
        end
        `RTC_IDX_COUNT: begin
          n.countWr = pwdata;
          n.countWrPend = 1'b1;
          start[`RTC_CH_COUNT] = 1'b1;
        end
        `RTC_IDX_MATCH0: begin
          n.match0Wr = pwdata;
          start[`RTC_CH_MATCH0] = 1'b1;
        end
        `RTC_IDX_SCRATCH0: begin
          n.scratch0 = pwdata;
          start[`RTC_CH_SCRATCH0] = 1'b1;
        end
        `RTC_IDX_SCRATCH1: begin
          n.scratch1 = pwdata;
          start[`RTC_CH_SCRATCH1] = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // set wins over a software clear in the same cycle
    n.irqFlags = (s.irqFlags & ~clrMask) | setMask;

    // counter-side completion of synchronized writes
    if (done[`RTC_CH_ENABLE]) begin
      n.enableLive = s.enable;
    end
    if (done[`RTC_CH_COUNT] && s.countWrPend) begin
      n.count = s.countWr;
      n.countWrPend = 1'b0;
    end
    if (done[`RTC_CH_MATCH0]) begin
      n.match0Value = s.match0Wr;
    end

    // finished soft reset: all back to zero except debug and bus answer
    if (done[`RTC_CH_SOFT_RESET]) begin
      n = '0;
      n.runInDebug = s.runInDebug;
      n.haltMeta = dbgHalt;
      n.haltSync = s.haltMeta;
      n.pready = psel & penable & ~s.pready;
      n.pslverr = n.pready & ~hit;
      n.prdata = (n.pready && !pwrite && hit) ? rdWord : `RTC_RESET_WORD;
    end

    n.irq = |(n.irqFlags & n.irqEnable);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign halted = s.haltSync & ~s.runInDebug;
  assign run = s.enableLive & ~halted;

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign evtOut = s.evt;
endmodule : rtc_wide_counter_mode_ctrl

// >>> verification/rtc_wide_counter_mode_ctrl_props.sv
// port assertions of the counter control block
`timescale 1ns/1ps
module rtc_wide_counter_mode_ctrl_props (
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              dbgHalt,
  input wire logic              irq,
  input wire rtc_pkg::rtc_evt_s evtOut
);
  logic [7:0] idx;
  logic       mapped;
  logic       wrTaken;
  logic [9:0] evSeen_q;
  logic       ienSeen_q;
  assign idx = paddr[9:2];
  assign mapped = paddr[11:10] == 2'h0 && idx inside {8'h00, 8'h04, 8'h08, 8'h0A, 8'h0C,
                  8'h0E, 8'h10, 8'h14, 8'h18, 8'h20, 8'h40, 8'h44};
  assign wrTaken = psel && penable && pready && pwrite;
  // enables ever written, an upper bound on what may fire
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      evSeen_q  <= 10'h000;
      ienSeen_q <= 1'b0;
    end else begin
      if (wrTaken && idx == 8'h04)
        evSeen_q <= evSeen_q | {pwdata[15], pwdata[8], pwdata[7:0]};
      if (wrTaken && idx == 8'h0A)
        ienSeen_q <= ienSeen_q | (|(pwdata[15:0] & 16'h81FF));
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer cycle");
  a_narrow_bits: assert property (
    pready && !pwrite && idx inside {8'h04, 8'h08, 8'h0A, 8'h0C} |-> (prdata & ~32'h81FF) == 0)
    else $error("undefined bits read nonzero");
  a_evt_ovf: assert property (evtOut.overflow |-> evSeen_q[9])
    else $error("overflow event while never enabled");
  a_evt_match: assert property (evtOut.match0 |-> evSeen_q[8])
    else $error("match event while never enabled");
  a_evt_per: assert property ((evtOut.periodic & ~evSeen_q[7:0]) == 8'h00)
    else $error("periodic event while never enabled");
  a_per_spacing: assert property (evtOut.periodic[0] |=> !evtOut.periodic[0] [*7])
    else $error("periodic event 0 too frequent");
  a_irq_gated: assert property (irq |-> ienSeen_q)
    else $error("irq with no enable ever set");
  c_overflow: cover property (evtOut.overflow);
  c_refused: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : rtc_wide_counter_mode_ctrl_props

bind rtc_wide_counter_mode_ctrl rtc_wide_counter_mode_ctrl_props u_props (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dbgHalt(dbgHalt), .irq(irq),
  .evtOut(evtOut));

// >>> verification/tb_rtc_wide_counter_mode_ctrl.sv
// self-checking bench of the counter control block
`timescale 1ns/1ps
module tb_rtc_wide_counter_mode_ctrl;
  localparam int SYNC = 16;
  logic              ref_clk;
  logic              reset;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              dbgHalt;
  logic              irq;
  rtc_pkg::rtc_evt_s evtOut;
  logic [9:0]        evtSeen;
  logic [31:0]       rd;
  logic [31:0]       cntA;
  logic              err;
  int                nErrors;
  int                samplesChecked;
  logic [7:0]        regIdx [7] = '{8'h00, 8'h04, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10};
  logic [7:0]        syncIdx [4] = '{8'h20, 8'h40, 8'h44, 8'h14};
  int                syncBit [4] = '{5, 16, 17, 2};

  rtc_wide_counter_mode_ctrl #(.SYNC_CYCLES(SYNC)) dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbgHalt(dbgHalt), .irq(irq), .evtOut(evtOut));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // sticky record of every event pulse
  always @(posedge ref_clk) begin
    if (reset)
      evtSeen <= 10'h000;
    else
      evtSeen <= evtSeen | evtOut;
  end

  task automatic testDone();
    if (nErrors == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : testDone

  task automatic valChk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      nErrors++;
    end
  endtask : valChk

  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      valChk(32'h1, 32'h0, "no ready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr

  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp,
                       input logic [31:0] m = 32'hFFFFFFFF);
    xfer(1'b0, idx, 32'h0);
    valChk({rd & m, 31'h0, err}, {exp, 32'h0}, "register read");
  endtask : rdChk

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dbgHalt = 1'b0;
    nErrors = 0;
    samplesChecked = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (regIdx[i]) rdChk(regIdx[i], 32'h0);
    xfer(1'b0, 8'h30, 32'h0);
    valChk({rd, 31'h0, err}, {32'h0, 32'h1}, "unmapped read");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'(m << 2));
      rdChk(8'h00, 32'(m << 2));
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rdChk(8'h04, 32'h000081FF);
    wr(8'h0A, 32'hFFFFFFFF);
    rdChk(8'h08, 32'h000081FF);
    wr(8'h08, 32'h00000100);
    wr(8'h0A, 32'h0);
    wr(8'h08, 32'h0);
    rdChk(8'h0A, 32'h000080FF);
    foreach (syncIdx[i]) begin
      wr(syncIdx[i], 32'h00000010);
      rdChk(8'h10, 32'h1 << syncBit[i]);
      repeat (SYNC + 8) @(posedge ref_clk);
      rdChk(8'h10, 32'h0);
    end
    rdChk(8'h44, 32'h00000010);
    wr(8'h18, 32'hFFFFFFE0);
    rdChk(8'h10, 32'h00000008);
    repeat (SYNC + 8) @(posedge ref_clk);
    wr(8'h00, 32'h00000202);
    rdChk(8'h00, 32'h00000202);
    rdChk(8'h10, 32'h00008002);
    repeat (SYNC + 8) @(posedge ref_clk);
    rdChk(8'h10, 32'h0);
    repeat (1100) @(posedge ref_clk);
    rdChk(8'h0C, 32'h000081FF);
    valChk({22'h0, evtSeen}, 32'h000003FF, "events");
    valChk({31'h0, irq}, 32'h1, "irq");
    rdChk(8'h18, 32'h0);
    wr(8'h00, 32'h0);
    repeat (SYNC + 8) @(posedge ref_clk);
    wr(8'h0C, 32'h0);
    rdChk(8'h0C, 32'h000081FF);
    wr(8'h0C, 32'h000081FF);
    rdChk(8'h0C, 32'h0);
    valChk({31'h0, irq}, 32'h0, "irq after clear");
    wr(8'h18, 32'h0);
    wr(8'h00, 32'h00008082);
    repeat (300) @(posedge ref_clk);
    rdChk(8'h0C, 32'h00000100);
    valChk({31'h0, irq}, 32'h0, "masked irq");
    wr(8'h0A, 32'h00000100);
    repeat (2) @(posedge ref_clk);
    valChk({31'h0, irq}, 32'h1, "unmasked irq");
    xfer(1'b0, 8'h18, 32'h0);
    valChk({31'h0, rd > 32'h10}, 32'h0, "count past match");
    rdChk(8'h10, 32'h00000008, 32'h00000008);
    dbgHalt <= 1'b1;
    repeat (8) @(posedge ref_clk);
    xfer(1'b0, 8'h18, 32'h0);
    cntA = rd;
    repeat (20) @(posedge ref_clk);
    xfer(1'b0, 8'h18, 32'h0);
    valChk(rd, cntA, "count under halt");
    wr(8'h0E, 32'h1);
    wr(8'h00, 32'h0);
    repeat (SYNC + 8) @(posedge ref_clk);
    wr(8'h00, 32'h0000008F);
    rdChk(8'h00, 32'h00000001, 32'h0000000F);
    rdChk(8'h10, 32'h00000001, 32'h00000001);
    repeat (SYNC + 8) @(posedge ref_clk);
    rdChk(8'h00, 32'h0);
    rdChk(8'h0A, 32'h0);
    rdChk(8'h04, 32'h0);
    rdChk(8'h0E, 32'h1);
    testDone();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    testDone();
  end
endmodule : tb_rtc_wide_counter_mode_ctrl
